/* File: spc_map.vh */
// register offsets, field positions, reset values and sizes of the segment playback control
`ifndef SPC_MAP_VH
`define SPC_MAP_VH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define SPC_SAMPLE_W      14
`define SPC_ADDR_W        25
`define SPC_SEG_W         14
`define SPC_SEG_COUNT     16384
`define SPC_EXT_W         8
`define SPC_MEM_STD       25'h0F42400
`define SPC_MEM_EXP       25'h1E84800

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SPC_REG_CTRL      8'h00
`define SPC_REG_SEG_SEL   8'h04
`define SPC_REG_TBL_IDX   8'h08
`define SPC_REG_TBL_START 8'h0C
`define SPC_REG_TBL_STOP  8'h10
`define SPC_REG_TBL_CMD   8'h14
`define SPC_REG_DL_ADDR   8'h18
`define SPC_REG_DL_DATA   8'h1C
`define SPC_REG_STATUS    8'h20
`define SPC_REG_STAT_CH0  8'h24
`define SPC_REG_STAT_CH1  8'h28

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SPC_CTRL_SRC0     0
`define SPC_CTRL_SRC1     1
`define SPC_CTRL_JUMP0    2
`define SPC_CTRL_JUMP1    3
`define SPC_CTRL_TARGET   4
`define SPC_CTRL_DL_CH    5
`define SPC_CMD_WRITE     0
`define SPC_CMD_CLEAR     1
`define SPC_SEL_CH1_LSB   16
`define SPC_STAT_PLAY     31
`define SPC_STAT_PEND     30

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SPC_CTRL_RST      6'h00

`endif

/* File: spc_playback.v */
// segment playback control: apb registers, segment table and two playback channels
// Operation
// - stream samples upward, one per clock
// - samples are 14 bits wide
// - sample code passes to converter untruncated
// - memory 16M samples, 32M with expansion
// - up to 16k segments
// - table holds start and stop per segment
// - only active segment plays; empty plays nothing
// - switch source remote by default, or external
// - undriven external select plays first segment
// - coherent switch by default, else immediate
// - clear empties table, keeps sample memory
// - download to analog or analog plus digital
// - select bus is 8 binary-weighted bits
// - codes 0 to 255 all accepted
// - change only on valid strobe transition
// - each channel has own select and strobe
`include "spc_map.vh"

// ----------------------------------------------------------------------------
// one playback channel
// ----------------------------------------------------------------------------
module spc_channel (
   // clock and reset
   input  wire                       core_clk,
   input  wire                       reset_n,
   input  wire                       ce,
   // settings
   input  wire                       src_ext,
   input  wire                       jump_now,
   input  wire                       rem_req,
   input  wire [`SPC_SEG_W-1:0]      rem_idx,
   // external select
   input  wire [`SPC_EXT_W-1:0]      ext_sel,
   input  wire                       ext_valid,
   // segment table lookup
   output wire [`SPC_SEG_W-1:0]      tbl_idx,
   input  wire [`SPC_ADDR_W-1:0]     tbl_start,
   input  wire [`SPC_ADDR_W-1:0]     tbl_stop,
   input  wire                       tbl_hit,
   // sample memory and converter
   output reg  [`SPC_ADDR_W-1:0]     mem_addr_q,
   input  wire [`SPC_SAMPLE_W-1:0]   mem_rdata,
   output reg  [`SPC_SAMPLE_W-1:0]   dac_data_q,
   output reg                        dac_valid_q,
   // status
   output reg                        pend_q,
   output reg  [`SPC_SEG_W-1:0]      cur_idx_q,
   output reg                        play_q
);
   reg [`SPC_EXT_W-1:0] sel_s1_q;
   reg [`SPC_EXT_W-1:0] sel_s2_q;
   reg                  vld_s1_q;
   reg                  vld_s2_q;
   reg                  vld_s3_q;
   reg [`SPC_EXT_W-1:0] ext_idx_q;
   reg                  src_d_q;
   reg [`SPC_SEG_W-1:0] pend_idx_q;
   reg                  rd_vld_q;
   reg [`SPC_ADDR_W-1:0] cur_stop_q;
   wire                 strobe_rise;
   wire                 new_req;
   reg  [`SPC_SEG_W-1:0] new_idx;
   wire                 at_stop;
   wire                 reload;

   assign strobe_rise = vld_s2_q & ~vld_s3_q;
   // the lookup follows a pending request, so the playing stop is held locally
   assign at_stop     = play_q & (mem_addr_q == cur_stop_q);
   // coherent waits for the stop address, immediate takes the request at once
   assign reload      = ~play_q | at_stop | (pend_q & jump_now);
   assign tbl_idx     = pend_q ? pend_idx_q : cur_idx_q;
   assign new_req     = (src_ext & ~src_d_q) | (src_ext & strobe_rise) | (~src_ext & rem_req);

   // request index: pins count as plain binary, code 0 is segment 0
   always @* begin
      new_idx = rem_idx;
      if (src_ext & strobe_rise)
         new_idx = {{(`SPC_SEG_W-`SPC_EXT_W){1'b0}}, sel_s2_q};
      else if (src_ext)
         new_idx = {{(`SPC_SEG_W-`SPC_EXT_W){1'b0}}, ext_idx_q};
   end

   // two-stage synchroniser; the second stage is looked at, and a third valid stage gives the strobe edge
   always @(posedge core_clk) begin
      if (!reset_n) begin
         sel_s1_q <= {`SPC_EXT_W{1'b0}};
         sel_s2_q <= {`SPC_EXT_W{1'b0}};
         vld_s1_q <= 1'b0;
         vld_s2_q <= 1'b0;
         vld_s3_q <= 1'b0;
         ext_idx_q <= {`SPC_EXT_W{1'b0}};
      end else if (ce) begin
         sel_s1_q <= ext_sel;
         sel_s2_q <= sel_s1_q;
         vld_s1_q <= ext_valid;
         vld_s2_q <= vld_s1_q;
         vld_s3_q <= vld_s2_q;
         if (strobe_rise)
            ext_idx_q <= sel_s2_q;
      end
   end

   // pending request; a new request in the switching cycle stays pending
   always @(posedge core_clk) begin
      if (!reset_n) begin
         pend_q     <= 1'b0;
         pend_idx_q <= {`SPC_SEG_W{1'b0}};
         src_d_q    <= 1'b0;
      end else if (ce) begin
         src_d_q <= src_ext;
         if (new_req) begin
            pend_q     <= 1'b1;
            pend_idx_q <= new_idx;
         end else if (reload) begin
            pend_q <= 1'b0;
         end
      end
   end

   // address walk; an empty or cleared segment stops output
   always @(posedge core_clk) begin
      if (!reset_n) begin
         mem_addr_q <= {`SPC_ADDR_W{1'b0}};
         cur_idx_q  <= {`SPC_SEG_W{1'b0}};
         cur_stop_q <= {`SPC_ADDR_W{1'b0}};
         play_q     <= 1'b0;
      end else if (ce) begin
         if (reload) begin
            cur_idx_q  <= tbl_idx;
            cur_stop_q <= tbl_stop;
            play_q     <= tbl_hit;
            mem_addr_q <= tbl_start;
         end else begin
            mem_addr_q <= mem_addr_q + 1'b1;
         end
      end
   end

   // memory answers one cycle after the address; data goes out unscaled
   always @(posedge core_clk) begin
      if (!reset_n) begin
         rd_vld_q    <= 1'b0;
         dac_valid_q <= 1'b0;
         dac_data_q  <= {`SPC_SAMPLE_W{1'b0}};
      end else if (ce) begin
         rd_vld_q    <= play_q;
         dac_valid_q <= rd_vld_q;
         dac_data_q  <= rd_vld_q ? mem_rdata : {`SPC_SAMPLE_W{1'b0}};
      end
   end
endmodule

// ----------------------------------------------------------------------------
// top: apb slave, segment table, download port, two channels
// ----------------------------------------------------------------------------
module spc_playback (
   // clock and reset
   input  wire                       core_clk,
   input  wire                       reset_n,
   input  wire                       ce,
   // memory expansion strap
   input  wire                       mem_exp,
   // apb slave
   input  wire                       psel,
   input  wire                       penable,
   input  wire                       pwrite,
   input  wire [7:0]                 paddr,
   input  wire [31:0]                pwdata,
   output reg  [31:0]                prdata_q,
   output reg                        pready_q,
   output reg                        pslverr_q,
   // external select, one group per channel
   input  wire [`SPC_EXT_W-1:0]      ext_sel0,
   input  wire                       ext_valid0,
   input  wire [`SPC_EXT_W-1:0]      ext_sel1,
   input  wire                       ext_valid1,
   // sample memory read ports
   output wire [`SPC_ADDR_W-1:0]     ch0_mem_addr,
   input  wire [`SPC_SAMPLE_W-1:0]   ch0_mem_rdata,
   output wire [`SPC_ADDR_W-1:0]     ch1_mem_addr,
   input  wire [`SPC_SAMPLE_W-1:0]   ch1_mem_rdata,
   // converters
   output wire [`SPC_SAMPLE_W-1:0]   dac0_data,
   output wire                       dac0_valid,
   output wire [`SPC_SAMPLE_W-1:0]   dac1_data,
   output wire                       dac1_valid,
   // download write port
   output reg  [1:0]                 mem_wr_en_q,
   output reg  [1:0]                 dig_wr_en_q,
   output reg  [`SPC_ADDR_W-1:0]     mem_wr_addr_q,
   output reg  [`SPC_SAMPLE_W-1:0]   mem_wr_data_q
);
   // segment table storage
   reg [`SPC_ADDR_W-1:0]  tbl_start_m [0:`SPC_SEG_COUNT-1];
   reg [`SPC_ADDR_W-1:0]  tbl_stop_m  [0:`SPC_SEG_COUNT-1];
   reg                    tbl_vld_m   [0:`SPC_SEG_COUNT-1];

   reg [5:0]              ctrl_q;
   reg [`SPC_SEG_W-1:0]   rem_idx0_q;
   reg [`SPC_SEG_W-1:0]   rem_idx1_q;
   reg [1:0]              rem_req_q;
   reg [`SPC_SEG_W-1:0]   tidx_q;
   reg [`SPC_ADDR_W-1:0]  tstart_q;
   reg [`SPC_ADDR_W-1:0]  tstop_q;
   reg [`SPC_ADDR_W-1:0]  dl_addr_q;
   reg                    clr_busy_q;
   reg [`SPC_SEG_W-1:0]   clr_idx_q;
   reg                    decode_ok;
   reg [31:0]             rd_mux;

   wire                   acc;
   wire                   wr_fire;
   wire [`SPC_ADDR_W-1:0] mem_cap;
   wire [`SPC_SEG_W-1:0]  lk_idx0;
   wire [`SPC_SEG_W-1:0]  lk_idx1;
   wire                   hit0;
   wire                   hit1;
   wire                   pend0;
   wire                   pend1;
   wire                   play0;
   wire                   play1;
   wire [`SPC_SEG_W-1:0]  cur0;
   wire [`SPC_SEG_W-1:0]  cur1;

   assign acc     = psel & penable & ~pready_q;
   assign wr_fire = psel & penable & pwrite & pready_q & decode_ok;
   assign mem_cap = mem_exp ? `SPC_MEM_EXP : `SPC_MEM_STD;
   // a segment plays only if its entry is present and its bounds are ordered
   assign hit0 = tbl_vld_m[lk_idx0] & (tbl_start_m[lk_idx0] <= tbl_stop_m[lk_idx0]);
   assign hit1 = tbl_vld_m[lk_idx1] & (tbl_start_m[lk_idx1] <= tbl_stop_m[lk_idx1]);

   // address decode and read data
   always @* begin
      decode_ok = 1'b1;
      rd_mux    = 32'h00000000;
      case (paddr)
         `SPC_REG_CTRL:      rd_mux = {26'h0000000, ctrl_q};
         `SPC_REG_SEG_SEL:   rd_mux = {2'h0, rem_idx1_q, 2'h0, rem_idx0_q};
         `SPC_REG_TBL_IDX:   rd_mux = {18'h00000, tidx_q};
         `SPC_REG_TBL_START: rd_mux = {7'h00, tstart_q};
         `SPC_REG_TBL_STOP:  rd_mux = {7'h00, tstop_q};
         `SPC_REG_TBL_CMD:   rd_mux = 32'h00000000;
         `SPC_REG_DL_ADDR:   rd_mux = {7'h00, dl_addr_q};
         `SPC_REG_DL_DATA:   rd_mux = 32'h00000000;
         `SPC_REG_STATUS:    rd_mux = {28'h0000000, mem_exp, pend1, pend0, clr_busy_q};
         `SPC_REG_STAT_CH0:  rd_mux = {play0, pend0, 16'h0000, cur0};
         `SPC_REG_STAT_CH1:  rd_mux = {play1, pend1, 16'h0000, cur1};
         default:            decode_ok = 1'b0;
      endcase
   end

   // apb answer one cycle into the access phase
   always @(posedge core_clk) begin
      if (!reset_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (ce) begin
         pready_q  <= acc;
         pslverr_q <= acc & ~decode_ok;
         prdata_q  <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
      end
   end

   // control registers and one-cycle remote requests
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ctrl_q     <= `SPC_CTRL_RST;
         rem_idx0_q <= {`SPC_SEG_W{1'b0}};
         rem_idx1_q <= {`SPC_SEG_W{1'b0}};
         rem_req_q  <= 2'b00;
         tidx_q     <= {`SPC_SEG_W{1'b0}};
         tstart_q   <= {`SPC_ADDR_W{1'b0}};
         tstop_q    <= {`SPC_ADDR_W{1'b0}};
      end else if (ce) begin
         rem_req_q <= 2'b00;
         if (wr_fire) begin
            case (paddr)
               `SPC_REG_CTRL: ctrl_q <= pwdata[5:0];
               `SPC_REG_SEG_SEL: begin
                  rem_idx0_q <= pwdata[`SPC_SEG_W-1:0];
                  rem_idx1_q <= pwdata[`SPC_SEL_CH1_LSB+`SPC_SEG_W-1:`SPC_SEL_CH1_LSB];
                  rem_req_q  <= 2'b11;
               end
               `SPC_REG_TBL_IDX:   tidx_q   <= pwdata[`SPC_SEG_W-1:0];
               `SPC_REG_TBL_START: tstart_q <= pwdata[`SPC_ADDR_W-1:0];
               `SPC_REG_TBL_STOP:  tstop_q  <= pwdata[`SPC_ADDR_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // table writes and the clear walk; clearing touches no sample memory
   always @(posedge core_clk) begin
      if (!reset_n) begin
         clr_busy_q <= 1'b1;
         clr_idx_q  <= {`SPC_SEG_W{1'b0}};
      end else if (ce) begin
         if (clr_busy_q) begin
            tbl_vld_m[clr_idx_q] <= 1'b0;
            clr_idx_q <= clr_idx_q + 1'b1;
            if (clr_idx_q == {`SPC_SEG_W{1'b1}})
               clr_busy_q <= 1'b0;
         end else if (wr_fire && paddr == `SPC_REG_TBL_CMD) begin
            if (pwdata[`SPC_CMD_CLEAR]) begin
               clr_busy_q <= 1'b1;
               clr_idx_q  <= {`SPC_SEG_W{1'b0}};
            end else if (pwdata[`SPC_CMD_WRITE] && tstop_q < mem_cap) begin
               tbl_start_m[tidx_q] <= tstart_q;
               tbl_stop_m[tidx_q]  <= tstop_q;
               tbl_vld_m[tidx_q]   <= 1'b1;
            end
         end
      end
   end

   // sample download, address steps after each word
   always @(posedge core_clk) begin
      if (!reset_n) begin
         dl_addr_q     <= {`SPC_ADDR_W{1'b0}};
         mem_wr_en_q   <= 2'b00;
         dig_wr_en_q   <= 2'b00;
         mem_wr_addr_q <= {`SPC_ADDR_W{1'b0}};
         mem_wr_data_q <= {`SPC_SAMPLE_W{1'b0}};
      end else if (ce) begin
         mem_wr_en_q <= 2'b00;
         dig_wr_en_q <= 2'b00;
         if (wr_fire && paddr == `SPC_REG_DL_ADDR) begin
            dl_addr_q <= pwdata[`SPC_ADDR_W-1:0];
         end else if (wr_fire && paddr == `SPC_REG_DL_DATA && dl_addr_q < mem_cap) begin
            mem_wr_en_q   <= ctrl_q[`SPC_CTRL_DL_CH] ? 2'b10 : 2'b01;
            dig_wr_en_q   <= ctrl_q[`SPC_CTRL_TARGET] ?
                             (ctrl_q[`SPC_CTRL_DL_CH] ? 2'b10 : 2'b01) : 2'b00;
            mem_wr_addr_q <= dl_addr_q;
            mem_wr_data_q <= pwdata[`SPC_SAMPLE_W-1:0];
            dl_addr_q     <= dl_addr_q + 1'b1;
         end
      end
   end

   // two independent channels
   spc_channel u_ch0 (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .ce         (ce),
      .src_ext    (ctrl_q[`SPC_CTRL_SRC0]),
      .jump_now   (ctrl_q[`SPC_CTRL_JUMP0]),
      .rem_req    (rem_req_q[0]),
      .rem_idx    (rem_idx0_q),
      .ext_sel    (ext_sel0),
      .ext_valid  (ext_valid0),
      .tbl_idx    (lk_idx0),
      .tbl_start  (tbl_start_m[lk_idx0]),
      .tbl_stop   (tbl_stop_m[lk_idx0]),
      .tbl_hit    (hit0),
      .mem_addr_q (ch0_mem_addr),
      .mem_rdata  (ch0_mem_rdata),
      .dac_data_q (dac0_data),
      .dac_valid_q(dac0_valid),
      .pend_q     (pend0),
      .cur_idx_q  (cur0),
      .play_q     (play0)
   );

   spc_channel u_ch1 (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .ce         (ce),
      .src_ext    (ctrl_q[`SPC_CTRL_SRC1]),
      .jump_now   (ctrl_q[`SPC_CTRL_JUMP1]),
      .rem_req    (rem_req_q[1]),
      .rem_idx    (rem_idx1_q),
      .ext_sel    (ext_sel1),
      .ext_valid  (ext_valid1),
      .tbl_idx    (lk_idx1),
      .tbl_start  (tbl_start_m[lk_idx1]),
      .tbl_stop   (tbl_stop_m[lk_idx1]),
      .tbl_hit    (hit1),
      .mem_addr_q (ch1_mem_addr),
      .mem_rdata  (ch1_mem_rdata),
      .dac_data_q (dac1_data),
      .dac_valid_q(dac1_valid),
      .pend_q     (pend1),
      .cur_idx_q  (cur1),
      .play_q     (play1)
   );
endmodule

/* File: spc_playback_assertions.sv */
// concurrent checks on the ports of the segment playback control
module spc_checker (
   // clock and reset
   input logic        core_clk,
   input logic        reset_n,
   input logic        ce,
   // apb answer
   input logic        psel,
   input logic        penable,
   input logic [31:0] prdata_q,
   input logic        pready_q,
   input logic        pslverr_q,
   // sample path
   input logic [13:0] ch0_mem_rdata,
   input logic [13:0] ch1_mem_rdata,
   input logic [13:0] dac0_data,
   input logic        dac0_valid,
   input logic [13:0] dac1_data,
   input logic        dac1_valid,
   // download strobes
   input logic [1:0]  mem_wr_en_q,
   input logic [1:0]  dig_wr_en_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------------
   // ce low freezes everything, so nothing is judged then
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n || !ce);
   property p_rdy_time;
      $rose(penable) && psel |=> pready_q;
   endproperty
   a_rdy_time: assert property (p_rdy_time) else $error("pready late");
   property p_rdy_pulse;
      pready_q |=> !pready_q;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
   property p_no_early;
      psel && !penable |=> !pready_q;
   endproperty
   a_no_early: assert property (p_no_early) else $error("pready in setup");
   property p_err_rdy;
      pslverr_q |-> pready_q && prdata_q == 32'h0;
   endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   property p_rdata_idle;
      !pready_q |-> prdata_q == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not idle");
   // the converter code must be the whole stored word, never cut down
   property p_dac0_src;
      dac0_valid |-> dac0_data == $past(ch0_mem_rdata);
   endproperty
   a_dac0_src: assert property (p_dac0_src) else $error("dac0 not memory word");
   property p_dac1_src;
      dac1_valid |-> dac1_data == $past(ch1_mem_rdata);
   endproperty
   a_dac1_src: assert property (p_dac1_src) else $error("dac1 not memory word");
   property p_idle0;
      !dac0_valid |-> dac0_data == 14'h0000;
   endproperty
   a_idle0: assert property (p_idle0) else $error("dac0 not quiet");
   property p_dig_pair;
      dig_wr_en_q != 2'b00 |-> dig_wr_en_q == mem_wr_en_q ##1 mem_wr_en_q == 2'b00;
   endproperty
   a_dig_pair: assert property (p_dig_pair) else $error("digital write alone");
endmodule

bind spc_playback spc_checker u_chk (.*);

/* File: spc_ctrl_model.sv */
// behavioural external controller on one segment select input
module spc_ctrl_model (
   // clock
   input  logic       core_clk,
   // select lines
   output logic [7:0] ext_sel,
   output logic       ext_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] code;
   int         cnt;
   initial begin
      ext_sel   = 8'hA5;
      ext_valid = 1'b0;
      code      = 8'h00;
      cnt       = 0;
   end
   // floating lines between requests flip every cycle, so a stale code never looks valid
   always @(posedge core_clk) begin
      if (cnt > 0) begin
         cnt       <= cnt - 1;
         ext_sel   <= code;
         ext_valid <= (cnt > 4); // strobe four cycles high, then four low
      end else begin
         ext_sel   <= ~ext_sel;
      end
   end
   // one request; returns right after a rising edge once the strobe has rested
   task automatic send(input logic [7:0] c);
      @(negedge core_clk);
      code = c;
      cnt  = 8;
      while (cnt > 0) @(posedge core_clk);
   endtask
endmodule

/* File: spc_playback_tb.sv */
// self-checking bench for the segment playback control
`include "spc_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------------
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic        mem_exp  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q;
   logic [7:0]  ext_sel0, ext_sel1;
   logic        ext_valid0, ext_valid1, dac0_valid, dac1_valid;
   logic [24:0] ch0_mem_addr, ch1_mem_addr, mem_wr_addr_q, cap_addr;
   logic [13:0] ch0_mem_rdata = 14'h0, ch1_mem_rdata = 14'h0;
   logic [13:0] dac0_data, dac1_data, mem_wr_data_q, cap_data;
   logic [1:0]  mem_wr_en_q, dig_wr_en_q, cap_en, cap_dig;
   int          num_errors = 0;
   int          compares   = 0;
   int          cycles     = 0;
   spc_playback dut (.ce(1'b1), .*);
   spc_ctrl_model m0 (.core_clk(core_clk), .ext_sel(ext_sel0), .ext_valid(ext_valid0));
   spc_ctrl_model m1 (.core_clk(core_clk), .ext_sel(ext_sel1), .ext_valid(ext_valid1));
   // ------------------------------------------------------------------------
   // clock, sample memories, download monitor, timeout
   // ------------------------------------------------------------------------
   always #5 core_clk = ~core_clk;
   // memories answer one cycle late; channel 1 inverts so the top sample bit gets used
   always @(posedge core_clk) begin
      ch0_mem_rdata <= ch0_mem_addr[13:0];
      ch1_mem_rdata <= ch1_mem_addr[13:0] ^ 14'h3FFF;
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         $display("ERROR timeout expected 0 seen %0d", cycles);
         conclude;
      end
   end
   always @(posedge core_clk) if (mem_wr_en_q != 2'b00) begin
      cap_en   <= mem_wr_en_q;
      cap_dig  <= dig_wr_en_q;
      cap_addr <= mem_wr_addr_q;
      cap_data <= mem_wr_data_q;
   end
   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   task automatic conclude;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // entered and left just after a rising edge; one idle cycle after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      chk("pready", 1, pready_q);
      r = prdata_q;
      e = pslverr_q;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   task automatic ent(input int i, input int s, input int p);
      wr(`SPC_REG_TBL_IDX, i);
      wr(`SPC_REG_TBL_START, s);
      wr(`SPC_REG_TBL_STOP, p);
      wr(`SPC_REG_TBL_CMD, 32'h1);
   endtask
   task automatic wait_idle;
      logic [31:0] r;
      int          n = 0;
      do begin
         rd(`SPC_REG_STATUS, r);
         n++;
      end while (r[0] !== 1'b0 && n < 9000);
      chk("status busy", 0, r[0]);
   endtask
   task automatic wait_addr(input logic ch, input logic [24:0] a, input int lim);
      int n = 0;
      while ((ch ? ch1_mem_addr : ch0_mem_addr) !== a && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      chk("mem addr", a, ch ? ch1_mem_addr : ch0_mem_addr);
   endtask
   task automatic in_seg(input logic ch, input logic [24:0] s, input int len);
      logic [24:0] a;
      repeat (12) begin
         @(posedge core_clk);
         a = ch ? ch1_mem_addr : ch0_mem_addr;
         chk("seg addr", 1, a >= s && a < s + len);
      end
   endtask
   // ------------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------------
   task automatic t_defaults;
      logic [31:0] r;
      logic        e;
      rd(`SPC_REG_CTRL, r);
      chk("ctrl", 0, r);
      rd(`SPC_REG_STATUS, r);
      chk("status", 32'h1, r);
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk("unmapped err", 1, e);
      wait_idle;
      chk("dac0 valid", 0, dac0_valid);
   endtask
   task automatic t_table;
      // segments 37 and 57 are equally long so both channels stay aligned
      ent(37, 100, 103);
      ent(57, 300, 303);
      ent(0, 200, 201);
      ent(255, 400, 401);
      ent(16383, 500, 503);
      ent(6, 1000, `SPC_MEM_STD - 1);
      ent(5, 0, `SPC_MEM_STD);
   endtask
   task automatic t_remote;
      logic [31:0] r;
      wr(`SPC_REG_SEG_SEL, 32'h0039_0025);
      wait_addr(0, 25'd100, 40);
      for (int k = 1; k < 6; k++) begin
         @(posedge core_clk);
         chk("ch0 addr", 100 + k % 4, ch0_mem_addr);
      end
      wait_addr(1, 25'd302, 12);
      repeat (2) @(posedge core_clk);
      chk("dac1 data", 14'd302 ^ 14'h3FFF, dac1_data);
      rd(`SPC_REG_STAT_CH0, r);
      chk("stat ch0", 32'h8000_0025, r);
   endtask
   task automatic t_coherent;
      logic [24:0] prev;
      int          n = 0;
      wr(`SPC_REG_SEG_SEL, 32'h0039_0000);
      while (ch0_mem_addr !== 25'd200 && n < 8) begin
         prev = ch0_mem_addr;
         @(posedge core_clk);
         n++;
      end
      chk("addr before switch", 103, prev);
      chk("addr after switch", 200, ch0_mem_addr);
   endtask
   task automatic t_immediate;
      wr(`SPC_REG_CTRL, 32'h04);
      wr(`SPC_REG_SEG_SEL, 32'h0039_3FFF);
      wait_addr(0, 25'd500, 4);
      wr(`SPC_REG_SEG_SEL, 32'h0039_0006);
      wait_addr(0, 25'd1005, 20);
      wr(`SPC_REG_SEG_SEL, 32'h0039_0025);
      wait_addr(0, 25'd100, 4);
   endtask
   task automatic t_empty;
      logic [31:0] r;
      wr(`SPC_REG_SEG_SEL, 32'h0039_0005);
      repeat (6) @(posedge core_clk);
      chk("dac0 valid", 0, dac0_valid);
      rd(`SPC_REG_STAT_CH0, r);
      chk("stat ch0", 32'h0000_0005, r);
   endtask
   task automatic t_external;
      logic [7:0]  codes [4] = '{8'd37, 8'd255, 8'd0, 8'd57};
      logic [24:0] starts [4] = '{25'd100, 25'd400, 25'd200, 25'd300};
      int          lens [4] = '{4, 2, 2, 4};
      wr(`SPC_REG_CTRL, 32'h05);
      wait_addr(0, 25'd200, 12);
      foreach (codes[i]) begin
         m0.send(codes[i]);
         wait_addr(0, starts[i], 6);
         in_seg(0, starts[i], lens[i]);
      end
   endtask
   task automatic t_second;
      m1.send(8'd37);
      in_seg(1, 25'd300, 4);
      wr(`SPC_REG_CTRL, 32'h0F);
      wait_addr(1, 25'd100, 8);
      in_seg(0, 25'd300, 4);
   endtask
   task automatic t_clear;
      wr(`SPC_REG_TBL_CMD, 32'h2);
      wait_idle;
      chk("dac0 valid", 0, dac0_valid);
      ent(37, 100, 103);
      m0.send(8'd37);
      wait_addr(0, 25'd100, 8);
   endtask
   task automatic t_download;
      wr(`SPC_REG_CTRL, 32'h10);
      wr(`SPC_REG_DL_ADDR, 32'd10);
      wr(`SPC_REG_DL_DATA, 32'h2ABC);
      @(posedge core_clk);
      chk("wr en", 2'b01, cap_en);
      chk("dig en", 2'b01, cap_dig);
      chk("wr addr", 10, cap_addr);
      chk("wr data", 14'h2ABC, cap_data);
      wr(`SPC_REG_CTRL, 32'h20);
      wr(`SPC_REG_DL_DATA, 32'h1555);
      @(posedge core_clk);
      chk("wr en", 2'b10, cap_en);
      chk("dig en", 2'b00, cap_dig);
      chk("wr addr", 11, cap_addr);
      mem_exp <= 1'b1;
      wr(`SPC_REG_DL_ADDR, `SPC_MEM_STD);
      wr(`SPC_REG_DL_DATA, 32'h0123);
      @(posedge core_clk);
      chk("wr addr exp", `SPC_MEM_STD, cap_addr);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_defaults;
      t_table;
      t_remote;
      t_coherent;
      t_immediate;
      t_empty;
      t_external;
      t_second;
      t_clear;
      t_download;
      conclude;
   end
endmodule
